// ---- logic/chain_filter_cfg.sv ----
`timescale 1ns/10ps
`include "chain_defs.svh"
// Overview of operation
// R1: comb bypass set passes input unchanged, no decimation or scaling.
// R2: comb decimation field holds rate minus one, 0 to 31.
// R3: comb decimation zero skips filtering but still applies the scale.
// R4: comb scale offsets gain; valid values are zero to twenty.
// R5: software should set comb scale to ceil(5*log2(M))-5.
// R6: stage enable bits 3..0 enable or bypass the four fixed stages.
// R7: mono-rate select bits 12:10 choose the source channel's second half-band output.
// R8: control bit 9 enables an interpolating half-band that doubles the rate.
// R9: control bit 7 runs the mono-rate filter at half clock rate.
// R10: mono-rate bits 6:4 hold tap count minus one.
// R11: mono-rate bits 3:2 scale output by 3, 2, 1 or 0 bit shifts.
// R12: mono-rate bypass bit 0 makes output equal input.
// R13: eight 6-bit two's complement mono-rate coefficients at 0x80 to 0x87.
// R14: decimating filter bit 11 passes its input straight through.
// R15: decimating filter bit 10 treats stored response as symmetric half.
// R16: decimating filter bits 9:8 scale output with the same encoding.
// R17: decimating filter bits 7:4 hold rate minus one; filtering always occurs.
// R18: decimating filter bits 3:0 set the decimation phase below the rate.
// R19: channel registers are shared; access register 0x02 selects target channels.
// R20: control changes realign counters so sample order and decimation stay consistent.
module chain_filter_cfg #(
  parameter int NCH = 6,
  parameter int NTAP = 8
) (
  input logic clock,
  input logic rstn,
  input chain_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  input logic in_valid,
  output logic in_ready,
  input chain_pkg::sample_t in_smp,
  output logic out_valid,
  input logic out_ready,
  output chain_pkg::sample_t out_smp
);
  import chain_pkg::*;

  typedef struct packed {
    logic [NCH-1:0] access;
    logic [NCH-1:0] cbyp;
    logic [NCH-1:0][4:0] cdec;
    logic [NCH-1:0][4:0] cscl;
    logic [NCH-1:0][4:0] ccnt;
    logic [NCH-1:0][3:0] en;
    logic [NCH-1:0][12:0] mctl;
    logic [NCH-1:0][11:0] dctl;
    logic [NCH-1:0][NTAP-1:0][5:0] coef;
    logic [NCH-1:0][39:0] acc;
    logic [NCH-1:0][15:0] p1;
    logic [NCH-1:0][15:0] p2;
    logic [NCH-1:0][15:0] dprev;
    logic [NCH-1:0][15:0] iprev;
    logic [NCH-1:0] t1;
    logic [NCH-1:0] t2;
    logic [NCH-1:0][3:0] dcnt;
    logic [NCH-1:0][NTAP-1:0][15:0] line;
    logic mid_v;
    logic mid_p;
    sample_t mid;
    logic tick;
    logic in_rdy;
    logic [15:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;
  logic go;
  logic step;
  logic [2:0] c;
  logic [2:0] d;
  logic [2:0] rch;
  logic dest_ok;
  logic signed [15:0] x;
  logic signed [39:0] sum;
  logic cv;
  logic signed [15:0] cy;
  logic signed [15:0] y1;
  logic v2;
  logic signed [15:0] y3;
  logic v4;
  logic [NTAP-1:0][15:0] ml;
  logic signed [25:0] msum;
  logic signed [15:0] my;
  logic signed [16:0] z;
  logic v5;
  logic signed [15:0] y5;
  logic b_valid;
  logic b_ready;
  sample_t b_data;

  function automatic logic signed [15:0] avg(input logic signed [15:0] a,
                                             input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction

  function automatic logic [2:0] src_of(input logic [2:0] sel);
    return sel[2] ? {2'b10, sel[0]} : {1'b0, sel[1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign in_ready = st.in_rdy;
  assign reg_rdata = st.rdata;

  always_comb
  begin
    next_st = st;
    next_st.tick = !st.tick;
    x = in_smp.data;
    c = in_smp.chan;
    go = in_valid && st.in_rdy && (in_smp.chan < 3'(NCH));
    sum = '0;
    cv = 1'b0;
    cy = x;
    y1 = x;
    v2 = 1'b0;
    y3 = x;
    v4 = 1'b0;
    d = 3'h0;
    dest_ok = 1'b0;
    ml = '0;
    msum = '0;
    my = st.mid.data;
    z = '0;
    v5 = 1'b0;
    y5 = '0;
    b_valid = 1'b0;
    b_data = st.mid;
    step = 1'b0;
    rch = 3'h0;
    for (int k = NCH - 1; k >= 0; k--)
      if (st.access[k])
        rch = 3'(k);

    // comb decimator per channel, integrate and dump
    if (go)
    begin
      sum = st.acc[c] + 40'(x);
      if (st.cbyp[c])
      begin
        cv = 1'b1; // R1
        cy = x;
      end
      else if (st.ccnt[c] == st.cdec[c])
      begin
        cv = 1'b1; // R2
        cy = 16'(sum >>> st.cscl[c]); // R3 R4
        next_st.acc[c] = '0;
        next_st.ccnt[c] = '0;
      end
      else
      begin
        next_st.acc[c] = sum;
        next_st.ccnt[c] = st.ccnt[c] + 5'h01;
      end
      // fixed stages, each bypassed when its enable is clear
      y1 = st.en[c][`EN_FIRST_FIXED] ? avg(cy, st.p1[c]) : cy; // R6
      if (cv)
        next_st.p1[c] = cy;
      v2 = cv;
      if (cv && st.en[c][`EN_FIRST_HALF])
      begin
        next_st.t1[c] = !st.t1[c]; // R6
        v2 = st.t1[c];
      end
      y3 = st.en[c][`EN_SECOND_FIXED] ? avg(y1, st.p2[c]) : y1; // R6
      if (v2)
        next_st.p2[c] = y1;
      v4 = v2;
      if (v2 && st.en[c][`EN_SECOND_HALF])
      begin
        next_st.t2[c] = !st.t2[c]; // R6
        v4 = st.t2[c];
      end
    end

    // route to the lowest mono-rate filter whose source is this channel
    for (int k = NCH - 1; k >= 0; k--)
      if (src_of(st.mctl[k][`MONO_SEL_HI:`MONO_SEL_LO]) == c)
      begin
        d = 3'(k); // R7
        dest_ok = 1'b1;
      end
    if (v4 && dest_ok)
    begin
      next_st.mid_v = 1'b1;
      next_st.mid_p = 1'b0;
      next_st.mid.chan = d;
      next_st.mid.data = y3;
    end

    // output step: mono-rate, decimating filter, interpolator
    d = st.mid.chan;
    step = st.mid_v && b_ready &&
           (st.mid_p || !st.mctl[d][`MONO_HALF] || st.tick); // R9
    if (step && st.mid_p)
    begin
      b_valid = 1'b1;
      next_st.mid_v = 1'b0;
    end
    else if (step)
    begin
      next_st.mid_v = 1'b0;
      ml = {st.line[d][NTAP-2:0], st.mid.data};
      for (int k = 0; k < NTAP; k++)
        if (3'(k) <= st.mctl[d][`MONO_TAPS_HI:`MONO_TAPS_LO])
          msum = msum + 26'($signed(ml[k]) * $signed(st.coef[d][k])); // R10
      if (st.mctl[d][`MONO_BYP])
        my = st.mid.data; // R12
      else
      begin
        next_st.line[d] = ml;
        my = 16'(msum >>> (`FULL_SCALE - st.mctl[d][`MONO_SCL_HI:`MONO_SCL_LO])); // R11
      end
      if (st.dctl[d][`DECIM_BYP])
      begin
        v5 = 1'b1; // R14
        y5 = my;
      end
      else
      begin
        // symmetric mode folds the previous sample onto the mirrored half
        z = st.dctl[d][`DECIM_SYM] ? {my[15], my} + {st.dprev[d][15], st.dprev[d]}
                                    : {my[15], my}; // R15
        next_st.dprev[d] = my;
        y5 = 16'(z >>> (`FULL_SCALE - st.dctl[d][`DECIM_SCL_HI:`DECIM_SCL_LO])); // R16
        v5 = st.dcnt[d] == st.dctl[d][`DECIM_PH_HI:`DECIM_PH_LO]; // R18
        next_st.dcnt[d] = (st.dcnt[d] == st.dctl[d][`DECIM_RATE_HI:`DECIM_RATE_LO]) ?
                          4'h0 : st.dcnt[d] + 4'h1; // R17
      end
      if (v5)
      begin
        b_valid = 1'b1;
        b_data.data = y5;
        if (st.mctl[d][`MONO_INTERP])
        begin
          // midpoint goes first, the new sample follows on the next push
          b_data.data = avg(y5, st.iprev[d]); // R8
          next_st.mid_v = 1'b1;
          next_st.mid_p = 1'b1;
          next_st.mid.data = y5;
          next_st.iprev[d] = y5;
        end
      end
    end

    // register writes land last so a realign beats a same-cycle sample
    if (reg_req.wr)
    begin
      if (reg_req.addr == `ACCESS_ADDR)
        next_st.access = reg_req.wdata[NCH-1:0];
      for (int k = 0; k < NCH; k++)
        if (st.access[k]) // R19
        begin
          if (reg_req.addr == `COMB_BYP_ADDR || reg_req.addr == `COMB_DEC_ADDR)
          begin
            next_st.acc[k] = '0; // R20
            next_st.ccnt[k] = '0;
            if (reg_req.addr == `COMB_BYP_ADDR)
              next_st.cbyp[k] = reg_req.wdata[0];
            else
              next_st.cdec[k] = reg_req.wdata[4:0];
          end
          else if (reg_req.addr == `COMB_SCL_ADDR)
            next_st.cscl[k] = (reg_req.wdata[4:0] > `SCALE_MAX) ? `SCALE_MAX
                              : reg_req.wdata[4:0]; // R4
          else if (reg_req.addr == `STAGE_EN_ADDR)
          begin
            next_st.en[k] = reg_req.wdata[3:0];
            next_st.t1[k] = 1'b0; // R20
            next_st.t2[k] = 1'b0;
          end
          else if (reg_req.addr == `MONO_CTL_ADDR)
            next_st.mctl[k] = reg_req.wdata[12:0];
          else if (reg_req.addr == `DECIM_CTL_ADDR)
          begin
            next_st.dctl[k] = reg_req.wdata[11:0];
            next_st.dcnt[k] = 4'h0; // R20
          end
          else if (reg_req.addr >= `COEF_BASE && reg_req.addr <= `COEF_LAST)
            next_st.coef[k][reg_req.addr[2:0]] = reg_req.wdata[5:0]; // R13
        end
    end

    // reads answer from the lowest selected channel
    if (reg_req.rd)
    begin
      if (reg_req.addr == `ACCESS_ADDR)
        next_st.rdata = 16'(st.access);
      else if (reg_req.addr == `COMB_BYP_ADDR)
        next_st.rdata = 16'(st.cbyp[rch]);
      else if (reg_req.addr == `COMB_DEC_ADDR)
        next_st.rdata = 16'(st.cdec[rch]);
      else if (reg_req.addr == `COMB_SCL_ADDR)
        next_st.rdata = 16'(st.cscl[rch]);
      else if (reg_req.addr == `STAGE_EN_ADDR)
        next_st.rdata = 16'(st.en[rch]);
      else if (reg_req.addr == `MONO_CTL_ADDR)
        next_st.rdata = 16'(st.mctl[rch]);
      else if (reg_req.addr == `DECIM_CTL_ADDR)
        next_st.rdata = 16'(st.dctl[rch]);
      else if (reg_req.addr >= `COEF_BASE && reg_req.addr <= `COEF_LAST)
        next_st.rdata = 16'(st.coef[rch][reg_req.addr[2:0]]);
      else
        next_st.rdata = 16'h0000;
    end

    // one sample in flight keeps per-channel history in order
    next_st.in_rdy = !next_st.mid_v;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.access <= `ACCESS_RST;
      for (int k = 0; k < NCH; k++)
      begin
        st.cbyp[k] <= `COMB_BYP_RST;
        st.en[k] <= `STAGE_EN_RST;
        st.mctl[k] <= `MONO_CTL_RST;
        st.dctl[k] <= `DECIM_CTL_RST;
      end
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////

  chain_out_buffer #(
    .W($bits(sample_t)),
    .DEPTH(2)
  ) chain_out_buffer_inst (
    .clock(clock),
    .rstn(rstn),
    .in_valid(b_valid),
    .in_ready(b_ready),
    .in_data(b_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_smp)
  );

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_comb_bypass: assert property (go && st.cbyp[c] |-> cv && cy == x) // R1
    else $error("comb bypass altered data");
  a_comb_rate: assert property (go && !st.cbyp[c] |-> cv == (st.ccnt[c] == st.cdec[c])) // R2
    else $error("comb output at wrong count");
  a_comb_scale: assert property (go && !st.cbyp[c] && st.cdec[c] == 5'h00 && st.acc[c] == '0 // R3
    |-> cy == 16'(40'(x) >>> st.cscl[c]))
    else $error("rate one did not scale");
  a_scale_range: assert property (st.cscl[rch] <= `SCALE_MAX) // R4
    else $error("comb scale above range");
  a_stage_enable: assert property (go && !st.en[c][`EN_FIRST_FIXED] |-> y1 == cy) // R6
    else $error("disabled fixed stage changed data");
  a_half_rate: assert property (step && !st.mid_p && st.mctl[d][`MONO_HALF] |-> st.tick) // R9
    else $error("half rate step off phase");
  a_mono_bypass: assert property (step && !st.mid_p && st.mctl[d][`MONO_BYP] // R12
    |-> my == st.mid.data)
    else $error("mono bypass altered data");
  a_decim_bypass: assert property (step && !st.mid_p && st.dctl[d][`DECIM_BYP] // R14
    |-> v5 && y5 == my)
    else $error("decimating bypass altered data");
  a_interp_pair: assert property (step && !st.mid_p && v5 && st.mctl[d][`MONO_INTERP] // R8
    |=> st.mid_v && st.mid_p && st.mid.data == $past(y5))
    else $error("interpolated second sample missing");
  a_chan_write: assert property (reg_req.wr && reg_req.addr == `COMB_DEC_ADDR // R19
    && st.access[0] |=> st.cdec[0] == $past(reg_req.wdata[4:0]) && st.ccnt[0] == 5'h00)
    else $error("selected channel not written");
  a_coef_write: assert property (reg_req.wr && reg_req.addr == `COEF_BASE && st.access[0] // R13
    |=> st.coef[0][0] == $past(reg_req.wdata[5:0]))
    else $error("coefficient write lost");
  a_decim_realign: assert property (reg_req.wr && reg_req.addr == `DECIM_CTL_ADDR // R20
    && st.access[0] |=> st.dcnt[0] == 4'h0)
    else $error("decimation phase not realigned");

  c_comb_full: cover property (go && cv && !st.cbyp[c] && st.cdec[c] == 5'h1f);
  c_interp: cover property (step && st.mid_p);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && !b_ready);
endmodule

// ---- logic/chain_defs.svh ----
`ifndef CHAIN_DEFS_SVH
`define CHAIN_DEFS_SVH
// register addresses: the global access select, then the channel-selected space
`define ACCESS_ADDR 8'h02
`define COEF_BASE 8'h80
`define COEF_LAST 8'h87
`define COMB_BYP_ADDR 8'h88
`define COMB_DEC_ADDR 8'h89
`define COMB_SCL_ADDR 8'h8a
`define STAGE_EN_ADDR 8'h8b
`define MONO_CTL_ADDR 8'h8c
`define DECIM_CTL_ADDR 8'h8d
// fixed stage enable bits
`define EN_FIRST_FIXED 3
`define EN_FIRST_HALF 2
`define EN_SECOND_FIXED 1
`define EN_SECOND_HALF 0
// mono-rate control fields
`define MONO_SEL_HI 12
`define MONO_SEL_LO 10
`define MONO_INTERP 9
`define MONO_HALF 7
`define MONO_TAPS_HI 6
`define MONO_TAPS_LO 4
`define MONO_SCL_HI 3
`define MONO_SCL_LO 2
`define MONO_BYP 0
// decimating filter control fields
`define DECIM_BYP 11
`define DECIM_SYM 10
`define DECIM_SCL_HI 9
`define DECIM_SCL_LO 8
`define DECIM_RATE_HI 7
`define DECIM_RATE_LO 4
`define DECIM_PH_HI 3
`define DECIM_PH_LO 0
// limits and reset values
`define SCALE_MAX 5'h14
`define FULL_SCALE 2'h3
`define ACCESS_RST 6'h01
`define COMB_BYP_RST 1'h1
`define STAGE_EN_RST 4'h0
`define MONO_CTL_RST 13'h0001
`define DECIM_CTL_RST 12'h800
`endif

// ---- logic/chain_pkg.sv ----
package chain_pkg;
  typedef struct packed {
    logic [2:0] chan;
    logic signed [15:0] data;
  } sample_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage

// ---- logic/chain_out_buffer.sv ----
`timescale 1ns/10ps
module chain_out_buffer #(
  parameter int W = 19,
  parameter int DEPTH = 2
) (
  input logic clock,
  input logic rstn,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0] full;
    logic [DEPTH-1:0][W-1:0] mem;
  } buf_state_t;
  buf_state_t st;
  buf_state_t next_st;
  logic push;
  logic pop;
  logic done;

  // ready looks at the registered top slot only, so a push never races a pop
  assign in_ready = !st.full[DEPTH-1];
  assign out_valid = st.full[0];
  assign out_data = st.mem[0];

  always_comb
  begin
    next_st = st;
    done = 1'b0;
    push = in_valid && !st.full[DEPTH-1];
    pop = st.full[0] && out_ready;
    if (pop)
    begin
      next_st.full = st.full >> 1;
      for (int i = 0; i < DEPTH - 1; i++)
        next_st.mem[i] = st.mem[i + 1];
    end
    if (push)
    begin
      for (int i = 0; i < DEPTH; i++)
        if (!next_st.full[i] && !done)
        begin
          next_st.mem[i] = in_data;
          next_st.full[i] = 1'b1;
          done = 1'b1;
        end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_head_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("head word changed while stalled");
  a_push_kept: assert property (in_valid && in_ready |=> out_valid)
    else $error("accepted word not visible");
endmodule

// ---- bench/channel_filter_chain_config_tb.sv ----
`timescale 1ns/10ps
`include "chain_defs.svh"
module channel_filter_chain_config_tb;
  import chain_pkg::*;
  logic clock;
  logic rstn;
  reg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic in_valid;
  logic in_ready;
  sample_t in_smp;
  logic out_valid;
  logic out_ready;
  sample_t out_smp;
  int failures;
  int checked;
  int n;
  logic [15:0] v;
  sample_t got[$];
  sample_t exq[$];
  logic [7:0] ra[10] = '{8'h02, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h80, 8'h87, 8'h40};
  logic [15:0] rv[10] = '{16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 16'h1, 16'h800, 16'h0, 16'h0, 16'h0};
  logic [3:0] sb[4] = '{4'h8, 4'h4, 4'h2, 4'h1};

  chain_filter_cfg chain_filter_cfg_inst (
    .clock(clock),
    .rstn(rstn),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_smp(in_smp),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_smp(out_smp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // sampled in the active region, so the word seen is the one held before the edge
  always @(posedge clock)
    if (rstn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back(out_smp);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    failures++;
    stop_test();
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge clock);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clock);
    reg_req.rd = 1'b0;
    v = reg_rdata;
  endtask

  // must clear lets a refused sample pass quietly, for the back-pressure test
  task automatic send(input logic [2:0] c, input int d, input bit must);
    int i;
    i = 0;
    @(negedge clock);
    while (in_ready !== 1'b1 && i < 20)
    begin
      @(negedge clock);
      i++;
    end
    if (in_ready !== 1'b1)
    begin
      if (must)
        hang();
    end
    else
    begin
      in_valid = 1'b1;
      in_smp.chan = c;
      in_smp.data = d[15:0];
      @(negedge clock);
      in_valid = 1'b0;
      n++;
    end
  endtask

  function automatic void ex(input logic [2:0] c, input int d);
    exq.push_back({c, d[15:0]});
  endfunction

  // skip drops leading words whose value hangs on history from earlier tests
  task automatic drain(input int skip);
    int i;
    i = 0;
    while (got.size() < exq.size() + skip && i < 200)
    begin
      @(negedge clock);
      i++;
    end
    if (got.size() < exq.size() + skip)
      hang();
    repeat (6) @(negedge clock);
    check(got.size(), exq.size() + skip);
    repeat (skip) void'(got.pop_front());
    foreach (exq[k])
      if (got.size() > k)
        check(got[k], exq[k]);
    got.delete();
    exq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    reg_req = '0;
    in_valid = 1'b0;
    in_smp = '0;
    out_ready = 1'b1;
    failures = 0;
    checked = 0;
    n = 0;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    for (int k = 0; k < 10; k++)
    begin
      rd(ra[k]);
      check(v, rv[k]);
    end
    done("reset");
    wr(`COMB_DEC_ADDR, 16'h001f);
    rd(`COMB_DEC_ADDR);
    check(v, 16'h001f);
    wr(`COMB_SCL_ADDR, 16'h0014);
    rd(`COMB_SCL_ADDR);
    check(v, {11'h0, `SCALE_MAX});
    for (int k = 0; k < 8; k++)
      wr(`COEF_BASE + 8'(k), 16'hffa0 + 16'(k));
    for (int k = 0; k < 8; k++)
    begin
      rd(`COEF_BASE + 8'(k));
      check(v, 16'h0020 + 16'(k));
    end
    done("registers");
    wr(`ACCESS_ADDR, 16'h0002);
    wr(`COMB_DEC_ADDR, 16'h0005);
    wr(`ACCESS_ADDR, 16'h0003);
    rd(`COMB_DEC_ADDR);
    check(v, 16'h001f);
    wr(`ACCESS_ADDR, 16'h0002);
    rd(`COMB_DEC_ADDR);
    check(v, 16'h0005);
    wr(`ACCESS_ADDR, 16'h0000);
    wr(`COMB_DEC_ADDR, 16'h0007);
    rd(`COMB_DEC_ADDR);
    check(v, 16'h001f);
    wr(`ACCESS_ADDR, 16'h0001);
    done("access");
    // a dangling half-sum must be discarded by the decimation rewrite
    wr(`COMB_DEC_ADDR, 16'h0001);
    wr(`COMB_SCL_ADDR, 16'h0001);
    wr(`COMB_BYP_ADDR, 16'h0000);
    send(0, 100, 1);
    wr(`COMB_DEC_ADDR, 16'h0001);
    send(0, 8, 1);
    send(0, 6, 1);
    ex(0, 7);
    drain(0);
    // recommended scale for a rate of four
    wr(`COMB_DEC_ADDR, 16'h0003);
    wr(`COMB_SCL_ADDR, 16'h0005);
    for (int j = 0; j < 4; j++)
      send(0, 32, 1);
    ex(0, 4);
    drain(0);
    wr(`COMB_DEC_ADDR, 16'h0000);
    wr(`COMB_SCL_ADDR, 16'h0002);
    send(0, -16, 1);
    ex(0, -4);
    drain(0);
    wr(`COMB_BYP_ADDR, 16'h0001);
    send(0, -16, 1);
    ex(0, -16);
    drain(0);
    done("comb");
    foreach (sb[k])
    begin
      wr(`STAGE_EN_ADDR, {12'h0, sb[k]});
      for (int j = 1; j < 5; j++)
        send(0, 10 * j, 1);
      if (sb[k] inside {4'h4, 4'h1})
      begin
        ex(0, 20);
        ex(0, 40);
        drain(0);
      end
      else
      begin
        ex(0, 15);
        ex(0, 25);
        ex(0, 35);
        drain(1);
      end
    end
    wr(`STAGE_EN_ADDR, 16'h0000);
    done("stages");
    wr(`COEF_BASE, 16'h0001);
    wr(`COEF_BASE + 8'h1, 16'h0002);
    for (int k = 2; k < 8; k++)
      wr(`COEF_BASE + 8'(k), 16'h0000);
    wr(`MONO_CTL_ADDR, 16'h001c);
    send(0, 8, 1);
    send(0, 16, 1);
    ex(0, 8);
    ex(0, 32);
    drain(0);
    for (int s = 0; s < 4; s++)
    begin
      wr(`MONO_CTL_ADDR, 16'(s * 4));
      send(0, 64, 1);
      ex(0, 64 >> (3 - s));
      drain(0);
    end
    wr(`COEF_BASE, 16'h003f);
    wr(`MONO_CTL_ADDR, 16'h000c);
    send(0, 40, 1);
    ex(0, -40);
    drain(0);
    for (int s = 0; s < 8; s++)
    begin
      wr(`MONO_CTL_ADDR, 16'({3'(s), 10'h001}));
      send(3'(s < 4 ? s : 4 + s % 2), 100 + s, 1);
      ex(0, 100 + s);
      drain(0);
    end
    send(0, 7, 1);
    send(6, 9, 1);
    ex(1, 7);
    drain(0);
    wr(`MONO_CTL_ADDR, 16'h0001);
    done("mono");
    wr(`DECIM_CTL_ADDR, 16'h0311);
    for (int j = 1; j < 5; j++)
      send(0, j, 1);
    ex(0, 2);
    ex(0, 4);
    drain(0);
    wr(`DECIM_CTL_ADDR, 16'h03ff);
    for (int j = 1; j < 17; j++)
      send(0, j, 1);
    ex(0, 16);
    drain(0);
    wr(`DECIM_CTL_ADDR, 16'h0000);
    send(0, 64, 1);
    ex(0, 8);
    drain(0);
    wr(`DECIM_CTL_ADDR, 16'h0700);
    send(0, 10, 1);
    send(0, 20, 1);
    ex(0, 30);
    drain(1);
    wr(`DECIM_CTL_ADDR, 16'h0f11);
    send(0, 5, 1);
    send(0, 6, 1);
    ex(0, 5);
    ex(0, 6);
    drain(0);
    wr(`DECIM_CTL_ADDR, 16'h0800);
    done("decimating");
    wr(`MONO_CTL_ADDR, 16'h0201);
    send(0, 20, 1);
    send(0, 40, 1);
    ex(0, 20);
    ex(0, 30);
    ex(0, 40);
    drain(1);
    wr(`MONO_CTL_ADDR, 16'h0081);
    send(0, 5, 1);
    send(0, 9, 1);
    ex(0, 5);
    ex(0, 9);
    drain(0);
    wr(`MONO_CTL_ADDR, 16'h0001);
    done("interpolate");
    // receiver stalls: words pile up and the input must refuse rather than drop
    out_ready = 1'b0;
    n = 0;
    for (int j = 0; j < 6; j++)
      send(0, 50 + j, 0);
    repeat (4) @(negedge clock);
    check(in_ready, 1'b0);
    check(out_smp.data, 16'h0032);
    for (int j = 0; j < n; j++)
      ex(0, 50 + j);
    out_ready = 1'b1;
    drain(0);
    done("stall");
    stop_test();
  end
endmodule
